// ### bench/lmcb_core_checker.sv
// port assertions for the configuration byte store
// assumes bind onto lmcb_core; one clock, sync active-high reset
`timescale 1ns/1ps
module lmcb_core_checker
    import lmcb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cold_restart,
    input wire logic edit_wr,
    input wire logic edit_rd,
    input wire logic [5:0] edit_byte,
    input wire logic [7:0] edit_wdata,
    input wire logic [7:0] edit_rdata,
    input wire logic edit_rvalid,
    input wire logic [5:0] floor_number,
    input wire logic [1:0] door_letter,
    input wire logic [2:0] bus_number,
    input wire logic [2:0] left_host_field,
    input wire logic [2:0] right_host_field,
    input wire logic [2:0] variant_host,
    input wire logic restart_pending,
    input wire logic configured,
    input wire logic left_host_only,
    input wire logic arrow_forced,
    input wire logic arrow_continue,
    input wire logic occupied_enable,
    input wire logic option_disabled,
    input wire logic [1:0][3:0] input_function,
    input wire logic [1:0] input_function_valid,
    input wire logic [1:0] shutdown_target_right,
    input wire logic [3:0] output_pin14_function,
    input wire logic [3:0] output_pin7_function
);
    // ==========
    // helpers
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    function automatic logic code_ok(input logic [3:0] c);
        return c inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};
    endfunction
    // ==========
    // assertions
    AST_READ_LATENCY: assert property (ce && edit_rd ##1 ce |=> edit_rvalid)
        else $error("read answer late or missing");
    AST_NO_STRAY_VALID: assert property ($rose(edit_rvalid) |-> $past(edit_rd, 2))
        else $error("read answer without request");
    AST_RSVD_READ_ZERO: assert property (ce && edit_rd && (edit_byte == 6'h00
        || edit_byte == LMCB_BYTE_UNUSED || edit_byte > 6'h18) ##1 ce |=> edit_rdata == 8'h00)
        else $error("unused byte read not zero");
    AST_CFG_BITS: assert property (ce && edit_wr && edit_byte == LMCB_BYTE_CFG |=>
        {option_disabled, occupied_enable, arrow_continue, arrow_forced, left_host_only,
        configured} == {$past(edit_wdata[7:6]), $past(edit_wdata[3:0])})
        else $error("config bits not applied");
    AST_FLOOR: assert property (ce && edit_wr && edit_byte == LMCB_BYTE_FLOOR |=>
        floor_number == $past(edit_wdata[5:0]))
        else $error("floor not applied");
    AST_OUT_PINS: assert property (ce && edit_wr && edit_byte == LMCB_BYTE_OUT_FN |=>
        {output_pin7_function, output_pin14_function} == $past(edit_wdata))
        else $error("output nibbles wrong");
    AST_ACTIVE_HOLD: assert property (!(ce && cold_restart) |=> $stable(door_letter)
        && $stable(bus_number) && $stable(left_host_field) && $stable(right_host_field)
        && $stable(variant_host))
        else $error("active copy changed without restart");
    AST_RESTART_CLEARS: assert property (ce && cold_restart |=> !restart_pending)
        else $error("restart left pending change");
    AST_INPUT_DECODE: assert property (ce && edit_wr && edit_byte == LMCB_BYTE_IN_A |->
        ##2 (input_function[0] == $past(edit_wdata[3:0], 2)
        && input_function_valid[0] == code_ok($past(edit_wdata[3:0], 2))
        && shutdown_target_right[0] == ($past(edit_wdata[3:0], 2) == 4'h6
        && $past(edit_wdata[5], 2))))
        else $error("input decode wrong");
endmodule // lmcb_core_checker

// ### bench/lmcb_ctrl_model.sv
// main controller model: edits bytes and restarts the module
// assumes clk shared with the block; requests start 1 ns after an edge
`timescale 1ns/1ps
module lmcb_ctrl_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic edit_rvalid,
    input wire logic [7:0] edit_rdata,
    output logic cold_restart,
    output logic edit_wr,
    output logic edit_rd,
    output logic [5:0] edit_byte,
    output logic [7:0] edit_wdata
);
    // ==========
    // byte_edit_permission, volatile
    logic edit_permit;
    initial
    begin
        {cold_restart, edit_wr, edit_rd, edit_permit} = 4'h0;
        edit_byte = 6'h00;
        edit_wdata = 8'h00;
    end
    always @(posedge clk)
        if (rst)
            edit_permit = 1'b0;
    task automatic allow();
        edit_permit = 1'b1;
    endtask
    // ==========
    // requests
    task automatic wr(input logic [5:0] b, input logic [7:0] d);
        if (edit_permit)
        begin
            @(posedge clk);
            #1;
            edit_byte = b;
            edit_wdata = d;
            edit_wr = 1'b1;
            @(posedge clk);
            #1;
            edit_wr = 1'b0;
            edit_wdata = ~d; // released lines must not look valid
        end
    endtask
    task automatic rd(input logic [5:0] b, output logic [7:0] d);
        @(posedge clk);
        #1;
        edit_byte = b;
        edit_rd = 1'b1;
        @(posedge clk);
        #1;
        edit_rd = 1'b0;
        @(posedge clk);
        #1;
        d = (edit_rvalid === 1'b1) ? edit_rdata : 8'hxx;
    endtask
    task automatic restart();
        @(posedge clk);
        #1;
        cold_restart = 1'b1;
        @(posedge clk);
        #1;
        cold_restart = 1'b0;
    endtask
endmodule // lmcb_ctrl_model

// ### bench/tb_landing_module_config_bytes.sv
// self-checking bench for the configuration byte store
// assumes newer version (bytes 13..24 present); clock enable held high
`timescale 1ns/1ps
module tb_landing_module_config_bytes;
    import lmcb_pkg::*;
    logic clk, rst, cold_restart, edit_wr, edit_rd, edit_rvalid, restart_pending;
    logic configured, left_host_only, arrow_forced, arrow_continue, occupied_enable;
    logic option_disabled;
    logic [5:0] edit_byte, floor_number;
    logic [7:0] edit_wdata, edit_rdata;
    logic [1:0] door_letter, input_function_valid, repeated_input_reporting;
    logic [1:0] shutdown_target_right;
    logic [2:0] bus_number, left_host_field, right_host_field, variant_host;
    logic [1:0][3:0] input_function;
    logic [1:0][7:0] host_mask_bits, special_function_number;
    logic [3:0] output_pin14_function, output_pin7_function;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    lmcb_ctrl_model m (.clk(clk), .rst(rst), .edit_rvalid(edit_rvalid),
        .edit_rdata(edit_rdata), .cold_restart(cold_restart), .edit_wr(edit_wr),
        .edit_rd(edit_rd), .edit_byte(edit_byte), .edit_wdata(edit_wdata));
    lmcb_core dut_u (.clk(clk), .rst(rst), .ce(1'b1), .cold_restart(cold_restart),
        .edit_wr(edit_wr), .edit_rd(edit_rd), .edit_byte(edit_byte),
        .edit_wdata(edit_wdata), .edit_rdata(edit_rdata), .edit_rvalid(edit_rvalid),
        .floor_number(floor_number), .door_letter(door_letter), .bus_number(bus_number),
        .left_host_field(left_host_field), .right_host_field(right_host_field),
        .variant_host(variant_host), .restart_pending(restart_pending),
        .configured(configured), .left_host_only(left_host_only),
        .arrow_forced(arrow_forced), .arrow_continue(arrow_continue),
        .occupied_enable(occupied_enable), .option_disabled(option_disabled),
        .input_function(input_function), .input_function_valid(input_function_valid),
        .repeated_input_reporting(repeated_input_reporting),
        .shutdown_target_right(shutdown_target_right), .host_mask_bits(host_mask_bits),
        .special_function_number(special_function_number),
        .output_pin14_function(output_pin14_function),
        .output_pin7_function(output_pin7_function));
    // ==========
    // common tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("counts: %0d compares, %0d mismatches", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic t_cfg();
        logic [7:0] d;
        m.rd(LMCB_BYTE_CFG, d);
        chk(d, LMCB_RESET_BYTE);
        m.wr(LMCB_BYTE_CFG, 8'hff);
        m.rd(LMCB_BYTE_CFG, d);
        chk(d, 8'hcf);
        chk({2'h0, option_disabled, occupied_enable, arrow_continue, arrow_forced,
            left_host_only, configured}, 8'h3f);
        m.wr(LMCB_BYTE_CFG, 8'h05);
        chk({4'h0, arrow_continue, arrow_forced, left_host_only, configured}, 8'h05);
        m.wr(LMCB_BYTE_CFG, 8'h09);
        chk({4'h0, arrow_continue, arrow_forced, left_host_only, configured}, 8'h09);
        m.wr(LMCB_BYTE_FLOOR, 8'hff);
        m.rd(LMCB_BYTE_FLOOR, d);
        chk(d, 8'h3f);
        m.wr(LMCB_BYTE_OUT_FN, 8'ha5);
        chk({output_pin7_function, output_pin14_function}, 8'ha5);
        $display("test cfg done");
    endtask
    task automatic t_restart();
        logic [7:0] d;
        m.wr(LMCB_BYTE_DOOR, 8'h02);
        m.wr(LMCB_BYTE_BUS, 8'hff);
        m.wr(LMCB_BYTE_HOST_SEL, 8'hda);
        m.wr(LMCB_BYTE_VARIANT, 8'hff);
        chk({restart_pending, door_letter, bus_number, 2'h0}, 8'h80);
        chk({1'b0, right_host_field, 1'b0, left_host_field}, 8'h00);
        m.rd(LMCB_BYTE_HOST_SEL, d);
        chk(d, 8'h52);
        m.restart();
        chk({restart_pending, door_letter, bus_number, 2'h0}, 8'h5c);
        chk({1'b0, right_host_field, 1'b0, left_host_field}, 8'h52);
        chk({5'h0, variant_host}, 8'h07);
        m.wr(LMCB_BYTE_DOOR, 8'h03);
        m.rd(LMCB_BYTE_DOOR, d);
        chk(d, 8'h02);
        $display("test restart done");
    endtask
    task automatic t_inputs();
        logic [7:0] d;
        logic ok;
        for (int c = 0; c < 16; c++)
        begin
            ok = c inside {2, 3, 4, 5, 6, 7, 9, 10, 11, 12, 13};
            m.wr(LMCB_BYTE_EXTRA_A, 8'h5a);
            m.wr(LMCB_BYTE_IN_A, {4'h3, c[3:0]});
            @(posedge clk);
            #1;
            chk({3'h0, repeated_input_reporting[0], input_function[0]}, {4'h1, c[3:0]});
            chk({6'h0, shutdown_target_right[0], input_function_valid[0]},
                {6'h0, c == 6, ok});
            chk(host_mask_bits[0], (c == 9 || c == 13) ? 8'h5a : 8'h00);
            chk(special_function_number[0], (c == 10) ? 8'h5a : 8'h00);
            m.rd(LMCB_BYTE_IN_A, d);
            chk(d, (c == 6) ? 8'h36 : {4'h1, c[3:0]});
        end
        m.wr(LMCB_BYTE_IN_B, 8'h06);
        @(posedge clk);
        #1;
        chk({6'h0, shutdown_target_right[1], input_function_valid[1]}, 8'h01);
        m.wr(LMCB_BYTE_EXTRA_B, 8'h81);
        m.wr(LMCB_BYTE_IN_B, 8'h0d);
        @(posedge clk);
        #1;
        chk(host_mask_bits[1], 8'h81);
        $display("test inputs done");
    endtask
    task automatic t_unused();
        logic [7:0] d;
        logic [5:0] ub[6] = '{6'h00, 6'h0c, 6'h19, 6'h29, 6'h2a, 6'h3f};
        foreach (ub[i])
        begin
            m.wr(ub[i], 8'hff);
            m.rd(ub[i], d);
            chk(d, 8'h00);
        end
        m.wr(LMCB_BYTE_EXT_LO, 8'ha7);
        m.wr(LMCB_BYTE_EXT_HI, 8'h3c);
        m.rd(LMCB_BYTE_EXT_LO, d);
        chk(d, 8'ha7);
        m.rd(LMCB_BYTE_EXT_HI, d);
        chk(d, 8'h3c);
        $display("test unused done");
    endtask
    task automatic t_rst2();
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        chk({floor_number, door_letter}, 8'h00);
        m.wr(LMCB_BYTE_FLOOR, 8'h21);
        chk({2'h0, floor_number}, 8'h00);
        m.allow();
        m.wr(LMCB_BYTE_FLOOR, 8'h21);
        chk({2'h0, floor_number}, 8'h21);
        $display("test second reset done");
    endtask
    // ==========
    // clock, timeout, main sequence
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000) // whole run needs about 220 cycles
        begin
            n_fail++;
            close_out();
        end
    end
    initial
    begin
        rst = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        m.allow();
        t_cfg();
        t_restart();
        t_inputs();
        t_unused();
        t_rst2();
        close_out();
    end
endmodule // tb_landing_module_config_bytes

bind lmcb_core lmcb_core_checker chk_u (.clk(clk), .rst(rst), .ce(ce),
    .cold_restart(cold_restart), .edit_wr(edit_wr), .edit_rd(edit_rd),
    .edit_byte(edit_byte), .edit_wdata(edit_wdata), .edit_rdata(edit_rdata),
    .edit_rvalid(edit_rvalid), .floor_number(floor_number), .door_letter(door_letter),
    .bus_number(bus_number), .left_host_field(left_host_field),
    .right_host_field(right_host_field), .variant_host(variant_host),
    .restart_pending(restart_pending), .configured(configured),
    .left_host_only(left_host_only), .arrow_forced(arrow_forced),
    .arrow_continue(arrow_continue), .occupied_enable(occupied_enable),
    .option_disabled(option_disabled), .input_function(input_function),
    .input_function_valid(input_function_valid),
    .shutdown_target_right(shutdown_target_right),
    .output_pin14_function(output_pin14_function),
    .output_pin7_function(output_pin7_function));

// ### common/lmcb_mem_if.sv
// link between the configuration core and its extended byte store
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface lmcb_mem_if #(
    parameter int AW = 4
);
    logic ce;
    logic we;
    logic [AW-1:0] waddr;
    logic [7:0] wdata;
    logic [AW-1:0] raddr;
    logic [7:0] rdata;

    modport ctrl (
        output ce,
        output we,
        output waddr,
        output wdata,
        output raddr,
        input rdata
    );
    modport store (
        input ce,
        input we,
        input waddr,
        input wdata,
        input raddr,
        output rdata
    );
endinterface

// ### common/lmcb_pkg.sv
// landing module configuration bytes: offsets, fields, reset values, codes
// assumes a byte-wide edit port driven by the main controller's network agent
package lmcb_pkg;

    // ==========================================================
    // byte map, numbered from one
    localparam int LMCB_NUM_BYTES = 41;
    localparam int LMCB_USED_BYTES = 24;
    localparam int LMCB_BASE_BYTES = 12;
    localparam int LMCB_EXT_FIRST = 13;
    localparam int LMCB_EXT_DEPTH = 12;
    localparam logic [5:0] LMCB_BYTE_FLOOR = 6'h01;
    localparam logic [5:0] LMCB_BYTE_DOOR = 6'h02;
    localparam logic [5:0] LMCB_BYTE_BUS = 6'h03;
    localparam logic [5:0] LMCB_BYTE_HOST_SEL = 6'h04;
    localparam logic [5:0] LMCB_BYTE_VARIANT = 6'h05;
    localparam logic [5:0] LMCB_BYTE_CFG = 6'h06;
    localparam logic [5:0] LMCB_BYTE_IN_A = 6'h07;
    localparam logic [5:0] LMCB_BYTE_IN_B = 6'h08;
    localparam logic [5:0] LMCB_BYTE_OUT_FN = 6'h09;
    localparam logic [5:0] LMCB_BYTE_EXTRA_A = 6'h0a;
    localparam logic [5:0] LMCB_BYTE_EXTRA_B = 6'h0b;
    localparam logic [5:0] LMCB_BYTE_UNUSED = 6'h0c;
    localparam logic [5:0] LMCB_BYTE_EXT_LO = 6'h0d;
    localparam logic [5:0] LMCB_BYTE_EXT_HI = 6'h18;

    // ==========================================================
    // writable-bit masks, reserved bits stay zero
    localparam logic [7:0] LMCB_MASK_FLOOR = 8'h3f;
    localparam logic [7:0] LMCB_MASK_DOOR = 8'h03;
    localparam logic [7:0] LMCB_MASK_BUS = 8'h07;
    localparam logic [7:0] LMCB_MASK_HOST_SEL = 8'h77;
    localparam logic [7:0] LMCB_MASK_VARIANT = 8'h07;
    localparam logic [7:0] LMCB_MASK_CFG = 8'hcf;
    localparam logic [7:0] LMCB_MASK_IN = 8'h1f;
    localparam logic [7:0] LMCB_MASK_IN_SEL = 8'h3f;
    localparam logic [7:0] LMCB_DOOR_MAX = 8'h02;

    // ==========================================================
    // field positions
    localparam int LMCB_RIGHT_LSB = 4;
    localparam int LMCB_LEFT_LSB = 0;
    localparam int LMCB_CFG_CONFIGURED = 0;
    localparam int LMCB_CFG_LEFT_ONLY = 1;
    localparam int LMCB_CFG_ARROW_FORCED = 2;
    localparam int LMCB_CFG_ARROW_CONT = 3;
    localparam int LMCB_CFG_OCCUPIED = 6;
    localparam int LMCB_CFG_OPT_DIS = 7;
    localparam int LMCB_IN_REPEAT = 4;
    localparam int LMCB_IN_TARGET = 5;
    localparam int LMCB_OUT14_LSB = 0;
    localparam int LMCB_OUT7_LSB = 4;

    // ==========================================================
    // reset values
    localparam logic [7:0] LMCB_RESET_BYTE = 8'h00;

    // ==========================================================
    // input function codes
    localparam logic [3:0] LMCB_FN_FIRE_RECALL = 4'h2;
    localparam logic [3:0] LMCB_FN_LANDING_PRIO = 4'h3;
    localparam logic [3:0] LMCB_FN_REMOTE_OFF = 4'h4;
    localparam logic [3:0] LMCB_FN_FIRE_SEL = 4'h5;
    localparam logic [3:0] LMCB_FN_REMOTE_OFF_SEL = 4'h6;
    localparam logic [3:0] LMCB_FN_SMOKE = 4'h7;
    localparam logic [3:0] LMCB_FN_PRIO_SEL = 4'h9;
    localparam logic [3:0] LMCB_FN_SPECIAL = 4'ha;
    localparam logic [3:0] LMCB_FN_FIRE_RESET = 4'hb;
    localparam logic [3:0] LMCB_FN_PRIO_SUPER = 4'hc;
    localparam logic [3:0] LMCB_FN_PRIO_SUPER_SEL = 4'hd;

    // ==========================================================
    // read pipeline: request, fetch, present
    localparam int LMCB_READ_LATENCY = 2;

endpackage

// ### core/lmcb_core.sv
// landing module configuration byte store with restart-latched fields
// assumes the edit port is driven synchronously to clk by the network agent
`timescale 1ns/1ps
// Functional notes
// - 41 byte locations numbered from one; only first 24 influence behaviour.
// - bytes 13 to 24 exist only in the newer module version.
// - door, bus number and host selection take effect only after restart.
// - host selection bits 6:4 hold right host index; bit 7 zero.
// - host selection bits 2:0 hold left host index; bit 3 zero.
// - byte 05 holds the served host index for the extended variant.
// - config byte: configured, left-only, occupied indicator, option disable; 4,5 reserved.
// - config bit 2: arrow source, menu setting or forced arrow.
// - config bit 3: arrow shows direction or onward continuation.
// - bytes 07/08: function code, repeated reporting, reserved upper bits.
// - input function codes 2-7, 9, a-d with their meanings.
// - selective remote shutdown: bit 5 picks left or right host.
// - special function: extra byte holds the special function number.
// - byte 09: low nibble output pin 14, high nibble output pin 7.
// - after host change the module leaves the old host's module list; the core only latches the new host selection at restart.
module lmcb_core
    import lmcb_pkg::*;
#(
    parameter bit NEWER_VERSION = 1'b1
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cold_restart,
    input wire logic edit_wr,
    input wire logic edit_rd,
    input wire logic [5:0] edit_byte,
    input wire logic [7:0] edit_wdata,
    output logic [7:0] edit_rdata,
    output logic edit_rvalid,
    output logic [5:0] floor_number,
    output logic [1:0] door_letter,
    output logic [2:0] bus_number,
    output logic [2:0] left_host_field,
    output logic [2:0] right_host_field,
    output logic [2:0] variant_host,
    output logic restart_pending,
    output logic configured,
    output logic left_host_only,
    output logic arrow_forced,
    output logic arrow_continue,
    output logic occupied_enable,
    output logic option_disabled,
    output logic [1:0][3:0] input_function,
    output logic [1:0] input_function_valid,
    output logic [1:0] repeated_input_reporting,
    output logic [1:0] shutdown_target_right,
    output logic [1:0][7:0] host_mask_bits,
    output logic [1:0][7:0] special_function_number,
    output logic [3:0] output_pin14_function,
    output logic [3:0] output_pin7_function
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [LMCB_BASE_BYTES-1:0][7:0] bytes;
        logic [1:0] door_act;
        logic [2:0] bus_act;
        logic [7:0] host_act;
        logic [2:0] variant_act;
        logic [1:0] rd_pipe;
        logic rd_from_mem;
        logic [7:0] rd_low;
        logic [7:0] rdata;
        logic [1:0][3:0] fn;
        logic [1:0] fn_valid;
        logic [1:0] rep;
        logic [1:0] target;
        logic [1:0][7:0] mask;
        logic [1:0][7:0] special;
    } lmcb_core_st_t;

    lmcb_core_st_t st_reg;
    lmcb_core_st_t st_next;

    lmcb_mem_if #(.AW(4)) mem_bus ();

    logic in_ext;
    logic [3:0] ext_index;
    logic [7:0] wmask;
    logic wr_ok;

    // ==========================================================
    // decode of the edited byte
    always_comb
    begin
        in_ext = NEWER_VERSION && (edit_byte >= LMCB_BYTE_EXT_LO)
            && (edit_byte <= LMCB_BYTE_EXT_HI);
        ext_index = 4'(edit_byte - LMCB_BYTE_EXT_LO);
        wr_ok = 1'b1;
        if (edit_byte == LMCB_BYTE_FLOOR)
        begin
            wmask = LMCB_MASK_FLOOR;
        end
        else if (edit_byte == LMCB_BYTE_DOOR)
        begin
            wmask = LMCB_MASK_DOOR;
            // letters beyond C are not kept
            wr_ok = (edit_wdata <= LMCB_DOOR_MAX);
        end
        else if (edit_byte == LMCB_BYTE_BUS)
        begin
            wmask = LMCB_MASK_BUS;
        end
        else if (edit_byte == LMCB_BYTE_HOST_SEL)
        begin
            wmask = LMCB_MASK_HOST_SEL;
        end
        else if (edit_byte == LMCB_BYTE_VARIANT)
        begin
            wmask = LMCB_MASK_VARIANT;
        end
        else if (edit_byte == LMCB_BYTE_CFG)
        begin
            wmask = LMCB_MASK_CFG;
        end
        else if ((edit_byte == LMCB_BYTE_IN_A) || (edit_byte == LMCB_BYTE_IN_B))
        begin
            // bit 5 only means something for the selective shutdown code
            wmask = (edit_wdata[3:0] == LMCB_FN_REMOTE_OFF_SEL)
                ? LMCB_MASK_IN_SEL : LMCB_MASK_IN;
        end
        else if ((edit_byte == LMCB_BYTE_OUT_FN) || (edit_byte == LMCB_BYTE_EXTRA_A)
            || (edit_byte == LMCB_BYTE_EXTRA_B))
        begin
            wmask = 8'hff;
        end
        else
        begin
            wmask = 8'h00;
            wr_ok = 1'b0;
        end
    end

    // ==========================================================
    // next state
    always_comb
    begin
        st_next = st_reg;

        // ----- edits take effect at once in the store
        if (edit_wr && wr_ok && (edit_byte >= LMCB_BYTE_FLOOR)
            && (edit_byte <= LMCB_BYTE_UNUSED))
        begin
            st_next.bytes[4'(edit_byte - LMCB_BYTE_FLOOR)] = edit_wdata & wmask;
        end

        // ----- restart-latched copies; writes alone never reach them
        if (cold_restart)
        begin
            st_next.door_act = st_reg.bytes[4'(LMCB_BYTE_DOOR - LMCB_BYTE_FLOOR)][1:0];
            st_next.bus_act = st_reg.bytes[4'(LMCB_BYTE_BUS - LMCB_BYTE_FLOOR)][2:0];
            st_next.host_act = st_reg.bytes[4'(LMCB_BYTE_HOST_SEL - LMCB_BYTE_FLOOR)];
            st_next.variant_act = st_reg.bytes[4'(LMCB_BYTE_VARIANT - LMCB_BYTE_FLOOR)][2:0];
        end

        // ----- read pipeline, fixed two-cycle latency
        st_next.rd_pipe = {st_reg.rd_pipe[0], edit_rd};
        if (edit_rd)
        begin
            st_next.rd_from_mem = in_ext;
            st_next.rd_low = ((edit_byte >= LMCB_BYTE_FLOOR) && (edit_byte < LMCB_BYTE_UNUSED))
                ? st_reg.bytes[4'(edit_byte - LMCB_BYTE_FLOOR)] : 8'h00;
        end
        if (st_reg.rd_pipe[0])
        begin
            st_next.rdata = st_reg.rd_from_mem ? mem_bus.rdata : st_reg.rd_low;
        end

        // ----- per-input function decode
        for (int i = 0; i < 2; i++)
        begin
            logic [7:0] cfg;
            logic [7:0] extra;
            cfg = st_reg.bytes[4'(LMCB_BYTE_IN_A - LMCB_BYTE_FLOOR) + 4'(i)];
            extra = st_reg.bytes[4'(LMCB_BYTE_EXTRA_A - LMCB_BYTE_FLOOR) + 4'(i)];
            st_next.fn[i] = cfg[3:0];
            st_next.rep[i] = cfg[LMCB_IN_REPEAT];
            st_next.fn_valid[i] = cfg[3:0] inside {LMCB_FN_FIRE_RECALL, LMCB_FN_LANDING_PRIO,
                LMCB_FN_REMOTE_OFF, LMCB_FN_FIRE_SEL, LMCB_FN_REMOTE_OFF_SEL, LMCB_FN_SMOKE,
                LMCB_FN_PRIO_SEL, LMCB_FN_SPECIAL, LMCB_FN_FIRE_RESET, LMCB_FN_PRIO_SUPER,
                LMCB_FN_PRIO_SUPER_SEL};
            st_next.target[i] = (cfg[3:0] == LMCB_FN_REMOTE_OFF_SEL)
                && cfg[LMCB_IN_TARGET];
            st_next.mask[i] = ((cfg[3:0] == LMCB_FN_PRIO_SEL)
                || (cfg[3:0] == LMCB_FN_PRIO_SUPER_SEL)) ? extra : 8'h00;
            st_next.special[i] = (cfg[3:0] == LMCB_FN_SPECIAL) ? extra : 8'h00;
        end
    end

    // ==========================================================
    // registers; reset wins over the clock enable
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else if (ce)
        begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // extended store, absent bytes read zero on older builds
    assign mem_bus.ce = ce;
    assign mem_bus.we = edit_wr && in_ext;
    assign mem_bus.waddr = ext_index;
    assign mem_bus.wdata = edit_wdata;
    assign mem_bus.raddr = in_ext ? ext_index : 4'hf;

    lmcb_ext_mem #(
        .DEPTH(LMCB_EXT_DEPTH),
        .AW(4)
    ) u_ext_mem (
        .clk(clk),
        .rst(rst),
        .mem(mem_bus.store)
    );

    // ==========================================================
    // outputs
    assign edit_rdata = st_reg.rdata;
    assign edit_rvalid = st_reg.rd_pipe[1];
    assign floor_number = st_reg.bytes[0][5:0];
    assign door_letter = st_reg.door_act;
    assign bus_number = st_reg.bus_act;
    // only the restart-latched copy names the hosts this module reports to
    assign left_host_field = st_reg.host_act[LMCB_LEFT_LSB +: 3];
    assign right_host_field = st_reg.host_act[LMCB_RIGHT_LSB +: 3];
    assign variant_host = st_reg.variant_act;
    assign restart_pending =
        (st_reg.bytes[4'(LMCB_BYTE_HOST_SEL - LMCB_BYTE_FLOOR)] != st_reg.host_act)
        || (st_reg.bytes[4'(LMCB_BYTE_DOOR - LMCB_BYTE_FLOOR)][1:0] != st_reg.door_act)
        || (st_reg.bytes[4'(LMCB_BYTE_BUS - LMCB_BYTE_FLOOR)][2:0] != st_reg.bus_act)
        || (st_reg.bytes[4'(LMCB_BYTE_VARIANT - LMCB_BYTE_FLOOR)][2:0]
            != st_reg.variant_act);
    assign configured = st_reg.bytes[5][LMCB_CFG_CONFIGURED];
    assign left_host_only = st_reg.bytes[5][LMCB_CFG_LEFT_ONLY];
    assign arrow_forced = st_reg.bytes[5][LMCB_CFG_ARROW_FORCED];
    assign arrow_continue = st_reg.bytes[5][LMCB_CFG_ARROW_CONT];
    assign occupied_enable = st_reg.bytes[5][LMCB_CFG_OCCUPIED];
    assign option_disabled = st_reg.bytes[5][LMCB_CFG_OPT_DIS];
    assign input_function = st_reg.fn;
    assign input_function_valid = st_reg.fn_valid;
    assign repeated_input_reporting = st_reg.rep;
    assign shutdown_target_right = st_reg.target;
    assign host_mask_bits = st_reg.mask;
    assign special_function_number = st_reg.special;
    assign output_pin14_function = st_reg.bytes[8][LMCB_OUT14_LSB +: 4];
    assign output_pin7_function = st_reg.bytes[8][LMCB_OUT7_LSB +: 4];
endmodule // lmcb_core

// ### core/lmcb_ext_mem.sv
// small byte store for the extended configuration locations
// assumes synchronous active-high reset; read data arrive one cycle later
`timescale 1ns/1ps
module lmcb_ext_mem
    import lmcb_pkg::*;
#(
    parameter int DEPTH = LMCB_EXT_DEPTH,
    parameter int AW = 4
)(
    input wire logic clk,
    input wire logic rst,
    lmcb_mem_if.store mem
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] cells;
        logic [7:0] rdata;
    } lmcb_mem_st_t;

    lmcb_mem_st_t st_reg;
    lmcb_mem_st_t st_next;

    // ==========================================================
    // storage and registered read port
    always_comb
    begin
        st_next = st_reg;
        if (mem.we && (int'(mem.waddr) < DEPTH))
        begin
            st_next.cells[mem.waddr] = mem.wdata;
        end
        st_next.rdata = (int'(mem.raddr) < DEPTH) ? st_reg.cells[mem.raddr] : 8'h00;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else if (mem.ce)
        begin
            st_reg <= st_next;
        end
    end

    assign mem.rdata = st_reg.rdata;
endmodule // lmcb_ext_mem
